// *** pss_cfg.svh ***
// pss_cfg.svh: offsets, field positions, reset values and timing counts of the pole-slip trip block
// assumes inclusion from the top module only
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
`define PSS_CLK_HZ 40000000
`define PSS_TICK_MS 1
`define PSS_MS_CYC (`PSS_CLK_HZ / 1000 * `PSS_TICK_MS)
`define PSS_OFS_CTRL 8'h00
`define PSS_OFS_MIN_CUR 8'h04
`define PSS_OFS_MAX_CYC 8'h08
`define PSS_OFS_DEAD_MS 8'h0c
`define PSS_OFS_PULSE_MS 8'h10
`define PSS_OFS_STATUS 8'h14
`define PSS_OFS_IRQ_STAT 8'h18
`define PSS_OFS_IRQ_MASK 8'h1c
`define PSS_CTRL_ON_BIT 0
`define PSS_IRQ_START_BIT 0
`define PSS_IRQ_TRIP_BIT 1
`define PSS_MIN_CUR_LO 8'h0a
`define PSS_MIN_CUR_HI 8'h1e
`define PSS_MAX_CYC_LO 4'h1
`define PSS_MAX_CYC_HI 4'ha
`define PSS_DEAD_LO 16'h03e8
`define PSS_DEAD_HI 16'hea60
`define PSS_PULSE_LO 16'h0001
`define PSS_RST_MIN_CUR 8'h0a
`define PSS_RST_MAX_CYC 4'h1
`define PSS_RST_DEAD_MS 16'h03e8
`define PSS_RST_PULSE_MS 16'h0064
`endif

// *** pss_pkg.sv ***
// pss_pkg.sv: types shared by the pole-slip trip block
// assumes pss_cfg.svh on the include path
package pss_pkg;
   typedef enum logic [1:0] {
      LS_OUT = 2'b00,
      LS_IN = 2'b01,
      LS_DEAD = 2'b10
   } pss_loop_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pss_apb_req_t;
   typedef struct packed {
      logic [2:0] in_zone;
      logic [2:0] r_neg;
   } pss_zone_t;
   typedef struct packed {
      logic [15:0] pos_seq;
      logic [15:0] neg_seq;
      logic [2:0][15:0] phase_mag;
   } pss_meas_t;
endpackage

// *** pss_trip.sv ***
// pss_trip.sv: pole-slip counting per loop, current condition, start/trip decision, apb registers
// assumes zone, sign, current and block inputs come from logic on i_ref_clk
//
// The address map and the APB register port are this design's own decisions.
`include "pss_cfg.svh"
// Function
// [RL1] trip only when at least two of three loop slip flags are set, enabled and not blocked.
// [RL2] an off/on operation setting; when off neither start nor trip may assert.
// [RL3] the block input, while high, inhibits the function so no trip is produced.
// [RL4] trip is a pulse whose length comes from a setting, not from the detection condition.
// [RL5] the dead-time setting in 1 ms steps up to 60000 ms bounds the wait for the next revolution.
// [RL6] start status and trip command are outputs of the block.
// [RL7] operation needs positive-sequence current above the minimum-current threshold.
// [RL8] operation also needs negative-sequence current below one sixth of that threshold.
// [RL9] the minimum-current threshold is an integer setting in steps of 1.
// [RL10] the current stage gives one sufficiency flag per phase.
// [RL11] on zone entry the resistive sign is stored and a slip counts only if it reversed at exit.
// [RL12] an opposite-side exit starts the dead timer and the next entry must come before it runs out.
// [RL13] a cycle-number setting gives how many revolutions set a loop's slip flag.
// [RL14] dead-time expiry without re-entry clears the loop count and its slip flag.
// [RL15] start asserts when any loop has a slip, currents are fine, enabled and unblocked.
module pss_trip
   import pss_pkg::*;
#(
   parameter int P_MS_CYC = `PSS_MS_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire pss_apb_req_t i_apb,
   input wire pss_zone_t i_zone,
   input wire pss_meas_t i_meas,
   input wire logic i_block,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_start,
   output logic o_trip,
   output logic o_irq,
   output logic [2:0] o_slip_flag,
   output logic [2:0] o_current_ok
);
   logic op_on_q, op_on_d;
   logic [7:0] min_cur_q, min_cur_d;
   logic [3:0] max_cyc_q, max_cyc_d;
   logic [15:0] dead_q, dead_d, pulse_q, pulse_d;
   logic [1:0] ist_q, ist_d, imask_q, imask_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
   logic [15:0] pre_q, pre_d;
   logic tick_q, tick_d;
   logic [2:0] cur_ok_q, cur_ok_d;
   logic [2:0] slip_w, any_w;
   logic [15:0] tcnt_q, tcnt_d;
   logic trip_q, trip_d, start_q, start_d, cond_q, cond_d;
   logic two_w, en_w, cond_w, start_w;
   logic acc_w, wr_w;

   // apb access phase; one wait state so every answer leaves a flop
   assign acc_w = i_apb.psel && i_apb.penable && !pready_q;
   assign wr_w = acc_w && i_apb.pwrite;

   // register file, reads and writes; writes clamp settings into their legal range
   always_comb begin
      op_on_d = op_on_q;
      min_cur_d = min_cur_q;
      max_cyc_d = max_cyc_q;
      dead_d = dead_q;
      pulse_d = pulse_q;
      imask_d = imask_q;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      pready_d = acc_w;
      // events set, write one clears; set wins over the clear
      ist_d = ist_q;
      if (wr_w && i_apb.paddr == `PSS_OFS_IRQ_STAT) ist_d = ist_q & ~i_apb.pwdata[1:0];
      if (start_w && !start_q) ist_d[`PSS_IRQ_START_BIT] = 1'b1;
      if (trip_d && !trip_q) ist_d[`PSS_IRQ_TRIP_BIT] = 1'b1;
      if (acc_w) begin
         prdata_d = 32'h0000_0000;
         unique case (i_apb.paddr)
            `PSS_OFS_CTRL: begin
               prdata_d[`PSS_CTRL_ON_BIT] = op_on_q;
               if (wr_w) op_on_d = i_apb.pwdata[`PSS_CTRL_ON_BIT]; // RL2
            end
            `PSS_OFS_MIN_CUR: begin
               prdata_d[7:0] = min_cur_q;
               if (wr_w) begin
                  // integer threshold, one count per step
                  min_cur_d = i_apb.pwdata[7:0]; // RL9
                  if (i_apb.pwdata[31:0] < 32'(`PSS_MIN_CUR_LO)) min_cur_d = `PSS_MIN_CUR_LO;
                  if (i_apb.pwdata[31:0] > 32'(`PSS_MIN_CUR_HI)) min_cur_d = `PSS_MIN_CUR_HI;
               end
            end
            `PSS_OFS_MAX_CYC: begin
               prdata_d[3:0] = max_cyc_q;
               if (wr_w) begin
                  max_cyc_d = i_apb.pwdata[3:0]; // RL13
                  if (i_apb.pwdata[31:0] < 32'(`PSS_MAX_CYC_LO)) max_cyc_d = `PSS_MAX_CYC_LO;
                  if (i_apb.pwdata[31:0] > 32'(`PSS_MAX_CYC_HI)) max_cyc_d = `PSS_MAX_CYC_HI;
               end
            end
            `PSS_OFS_DEAD_MS: begin
               prdata_d[15:0] = dead_q;
               if (wr_w) begin
                  dead_d = i_apb.pwdata[15:0]; // RL5
                  if (i_apb.pwdata[31:0] < 32'(`PSS_DEAD_LO)) dead_d = `PSS_DEAD_LO;
                  if (i_apb.pwdata[31:0] > 32'(`PSS_DEAD_HI)) dead_d = `PSS_DEAD_HI;
               end
            end
            `PSS_OFS_PULSE_MS: begin
               prdata_d[15:0] = pulse_q;
               if (wr_w) begin
                  pulse_d = i_apb.pwdata[15:0]; // RL4
                  if (i_apb.pwdata[31:16] != 16'h0000) pulse_d = 16'hffff;
                  if (i_apb.pwdata[31:0] == 32'h0000_0000) pulse_d = `PSS_PULSE_LO;
               end
            end
            `PSS_OFS_STATUS: prdata_d[10:0] = {cur_ok_q, slip_w, any_w, trip_q, start_q};
            `PSS_OFS_IRQ_STAT: prdata_d[1:0] = ist_q;
            `PSS_OFS_IRQ_MASK: begin
               prdata_d[1:0] = imask_q;
               if (wr_w) imask_d = i_apb.pwdata[1:0];
            end
            default: pslverr_d = 1'b1;
         endcase
      end
      irq_d = |(ist_d & imask_d);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         op_on_q <= 1'b0;
         min_cur_q <= `PSS_RST_MIN_CUR;
         max_cyc_q <= `PSS_RST_MAX_CYC;
         dead_q <= `PSS_RST_DEAD_MS;
         pulse_q <= `PSS_RST_PULSE_MS;
         ist_q <= 2'h0;
         imask_q <= 2'h0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         op_on_q <= op_on_d;
         min_cur_q <= min_cur_d;
         max_cyc_q <= max_cyc_d;
         dead_q <= dead_d;
         pulse_q <= pulse_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
      end
   end

   // millisecond tick shared by dead timers and trip pulse
   always_comb begin
      pre_d = pre_q + 16'h0001;
      tick_d = 1'b0;
      if (pre_q >= 16'(P_MS_CYC - 1)) begin
         pre_d = 16'h0000;
         tick_d = 1'b1;
      end
   end

   // current condition per phase; the 6x product avoids a divider
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         cur_ok_d[p] = op_on_q && (i_meas.phase_mag[p] > {8'h00, min_cur_q}) // RL10
                       && (i_meas.pos_seq > {8'h00, min_cur_q}) // RL7
                       && (({3'b000, i_meas.neg_seq} * 19'd6) < {11'h000, min_cur_q}); // RL8
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         pre_q <= 16'h0000;
         tick_q <= 1'b0;
         cur_ok_q <= 3'b000;
      end else begin
         pre_q <= pre_d;
         tick_q <= tick_d;
         cur_ok_q <= cur_ok_d;
      end
   end

   // one revolution counter per phase-to-phase loop
   genvar g;
   for (g = 0; g < 3; g++) begin : g_loop
      pss_loop_state_t st_q, st_d;
      logic sign_q, sign_d, flag_q, flag_d;
      logic [3:0] cnt_q, cnt_d;
      logic [15:0] tmr_q, tmr_d;
      always_comb begin
         st_d = st_q;
         sign_d = sign_q;
         flag_d = flag_q;
         cnt_d = cnt_q;
         tmr_d = tmr_q;
         unique case (st_q)
            LS_OUT: begin
               if (i_zone.in_zone[g]) begin
                  sign_d = i_zone.r_neg[g]; // RL11
                  st_d = LS_IN;
               end
            end
            LS_IN: begin
               if (!i_zone.in_zone[g]) begin
                  if (i_zone.r_neg[g] != sign_q) begin
                     // slip counted; saturate so the flag cannot wrap off
                     if (cnt_q != 4'hf) cnt_d = cnt_q + 4'h1; // RL11
                     if (cnt_q + 4'h1 >= max_cyc_q) flag_d = 1'b1; // RL13
                     tmr_d = dead_q; // RL5 RL12
                     st_d = LS_DEAD;
                  end else begin
                     // swing turned back on the entry side, stable
                     cnt_d = 4'h0;
                     flag_d = 1'b0;
                     st_d = LS_OUT;
                  end
               end
            end
            LS_DEAD: begin
               if (i_zone.in_zone[g]) begin
                  sign_d = i_zone.r_neg[g]; // RL12
                  st_d = LS_IN;
               end else if (tick_q) begin
                  if (tmr_q <= 16'h0001) begin
                     cnt_d = 4'h0; // RL14
                     flag_d = 1'b0;
                     tmr_d = 16'h0000;
                     st_d = LS_OUT;
                  end else begin
                     tmr_d = tmr_q - 16'h0001;
                  end
               end
            end
            default: st_d = LS_OUT;
         endcase
         // disabled function forgets all history
         if (!op_on_q) begin
            st_d = LS_OUT;
            cnt_d = 4'h0;
            flag_d = 1'b0;
         end
      end
      always_ff @(posedge i_ref_clk) begin
         if (i_reset) begin
            st_q <= LS_OUT;
            sign_q <= 1'b0;
            flag_q <= 1'b0;
            cnt_q <= 4'h0;
            tmr_q <= 16'h0000;
         end else begin
            st_q <= st_d;
            sign_q <= sign_d;
            flag_q <= flag_d;
            cnt_q <= cnt_d;
            tmr_q <= tmr_d;
         end
      end
      assign slip_w[g] = flag_q;
      assign any_w[g] = (cnt_q != 4'h0);
      AST_DEAD_LOAD: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL12
         (st_q == LS_IN && !i_zone.in_zone[g] && i_zone.r_neg[g] != sign_q && op_on_q) |=> (tmr_q == $past(dead_q)))
         else $error("dead timer not loaded on opposite exit");
      AST_SAME_SIDE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL11
         (st_q == LS_IN && !i_zone.in_zone[g] && i_zone.r_neg[g] == sign_q) |=> (cnt_q == 4'h0 && !flag_q))
         else $error("same side exit counted as slip");
      AST_FLAG_COUNT: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL13
         $rose(flag_q) |-> (cnt_q >= max_cyc_q))
         else $error("slip flag set below cycle number");
      AST_EXPIRE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL14
         (st_q == LS_DEAD && tick_q && tmr_q == 16'h0001 && !i_zone.in_zone[g]) |=> (!flag_q && cnt_q == 4'h0))
         else $error("loop not cleared on dead time expiry");
   end

   // two of three vote, gated by operation, block and currents
   assign two_w = (slip_w[0] && slip_w[1]) || (slip_w[1] && slip_w[2]) || (slip_w[2] && slip_w[0]); // RL1
   assign en_w = op_on_q && !i_block && (&cur_ok_q); // RL2 RL3
   assign cond_w = two_w && en_w; // RL1
   assign start_w = (|any_w) && en_w; // RL15

   // trip pulse of set length, started only when the gated vote cond_w rises
   always_comb begin
      cond_d = cond_w;
      start_d = start_w;
      trip_d = trip_q;
      tcnt_d = tcnt_q;
      if (!en_w) begin
         trip_d = 1'b0; // RL3
         tcnt_d = 16'h0000;
      end else if (cond_w && !cond_q) begin
         trip_d = 1'b1; // RL4
         tcnt_d = pulse_q;
      end else if (trip_q && tick_q) begin
         if (tcnt_q <= 16'h0001) begin
            trip_d = 1'b0;
            tcnt_d = 16'h0000;
         end else begin
            tcnt_d = tcnt_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         cond_q <= 1'b0;
         start_q <= 1'b0;
         trip_q <= 1'b0;
         tcnt_q <= 16'h0000;
      end else begin
         cond_q <= cond_d;
         start_q <= start_d;
         trip_q <= trip_d;
         tcnt_q <= tcnt_d;
      end
   end

   // outputs straight from flops
   assign o_start = start_q; // RL6
   assign o_trip = trip_q; // RL6
   assign o_irq = irq_q;
   assign o_slip_flag = slip_w;
   assign o_current_ok = cur_ok_q;
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;

   AST_TRIP_VOTE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL1
      $rose(trip_q) |-> $past(two_w && en_w))
      else $error("trip without two loop vote");
   AST_OFF_QUIET: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL2
      !op_on_q |=> (!trip_q && !start_q))
      else $error("output while function off");
   AST_BLOCK: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL3
      i_block |=> !trip_q)
      else $error("trip while blocked");
   AST_PULSE_LOAD: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL4
      $rose(trip_q) |-> (tcnt_q == $past(pulse_q)))
      else $error("trip pulse length not loaded");
   AST_PULSE_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL4
      (trip_q && !tick_q && en_w) |=> trip_q)
      else $error("trip dropped before pulse end");
   AST_START: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL15
      start_q |-> $past(op_on_q && !i_block && (|any_w)))
      else $error("start without slip or enable");
   AST_CUR_POS: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL7
      cur_ok_q[0] |-> $past(i_meas.pos_seq > {8'h00, min_cur_q}))
      else $error("current ok with low positive sequence");
   AST_CUR_NEG: assert property (@(posedge i_ref_clk) disable iff (i_reset) // RL8
      cur_ok_q[1] |-> $past(({3'b000, i_meas.neg_seq} * 19'd6) < {11'h000, min_cur_q}))
      else $error("current ok with high negative sequence");
endmodule // pss_trip

// *** pss_zone_model.sv ***
// pss_zone_model.sv: behavioural impedance comparator feeding the zone flags
// assumes go is pulsed for one cycle by the bench while busy is low
module pss_zone_model
   import pss_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_go,
   input wire logic [2:0] i_loops,
   input wire logic [7:0] i_dwell,
   input wire logic i_same,
   output pss_zone_t o_zone,
   output logic o_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q;
   logic side_q;
   initial begin
      o_zone = '0;
      o_busy = 1'b0;
      side_q = 1'b0;
      cnt_q = '0;
   end
   // one revolution: enter on one r side, leave dwell+1 cycles after entry
   always @(posedge i_ref_clk) begin
      if (i_go && !o_busy) begin
         o_zone.in_zone <= i_loops;
         o_zone.r_neg <= {3{side_q}};
         cnt_q <= i_dwell;
         o_busy <= 1'b1;
      end else if (o_busy && cnt_q == 8'h00) begin
         o_zone.in_zone <= '0;
         // same-side exit is the commanded stable-swing case
         o_zone.r_neg <= {3{side_q ^ !i_same}};
         side_q <= side_q ^ !i_same;
         o_busy <= 1'b0;
      end else if (o_busy) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule // pss_zone_model

// *** pss_trip_tb.sv ***
// pss_trip_tb.sv: self-checking bench for the pole-slip trip block
// assumes pss_pkg and the zone model compiled first; ms tick shortened to 4 cycles
module pss_trip_tb import pss_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MSC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic blk = 1'b0;
   logic go = 1'b0;
   logic same = 1'b0;
   logic [2:0] loops = '0;
   logic [7:0] dwell = 8'h02;
   pss_apb_req_t apb = '0;
   pss_meas_t meas = '0;
   pss_zone_t zone;
   logic busy, pready, pslverr, start, trip, irq;
   logic [31:0] prdata, rdv;
   logic [2:0] slip, cur_ok;
   logic rerr;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   int trip_cyc = 0;

   always #12.5 clk = ~clk;
   // hang guard and trip width counter
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (trip === 1'b1) trip_cyc <= trip_cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end

   pss_trip #(.P_MS_CYC(MSC)) uut (.i_ref_clk(clk), .i_reset(rst), .i_apb(apb), .i_zone(zone),
      .i_meas(meas), .i_block(blk), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_start(start), .o_trip(trip), .o_irq(irq), .o_slip_flag(slip), .o_current_ok(cur_ok));
   pss_zone_model zm (.i_ref_clk(clk), .i_go(go), .i_loops(loops), .i_dwell(dwell),
      .i_same(same), .o_zone(zone), .o_busy(busy));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // apb transfer; pready is read before the edge's updates land
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      apb <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      apb.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk(32'h0, 32'h1);
      rdv = prdata;
      rerr = pslverr;
      apb <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
      xfer(1'b0, a, 32'h0);
      chk(rdv, exp);
      chk(32'(rerr), 32'(eexp));
   endtask

   // one revolution on the chosen loops, random dwell for slow and prompt swings
   task automatic rev(input logic [2:0] m, input logic s);
      @(posedge clk);
      loops <= m;
      same <= s;
      dwell <= 8'($urandom_range(1, 12));
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask

   function automatic logic [2:0] exp_cur(input int t, input pss_meas_t m);
      for (int k = 0; k < 3; k++)
         exp_cur[k] = m.phase_mag[k] > t && m.pos_seq > t && 6 * m.neg_seq < t;
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      int thr;
      void'($urandom(32'hd02c));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // every output idles low straight after reset
      @(posedge clk);
      chk(32'({slip, start, trip, irq, cur_ok, pready, pslverr}), 32'h0);
      // reset values, then an unmapped place
      rd(8'h00, 32'h0, 1'b0);
      rd(8'h04, 32'h0a, 1'b0);
      rd(8'h08, 32'h1, 1'b0);
      rd(8'h0c, 32'h3e8, 1'b0);
      rd(8'h10, 32'h64, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      // out-of-range settings land on the nearest legal value
      xfer(1'b1, 8'h0c, 32'h0001_0000);
      rd(8'h0c, 32'hea60, 1'b0);
      xfer(1'b1, 8'h0c, 32'h0000_0001);
      rd(8'h0c, 32'h3e8, 1'b0);
      xfer(1'b1, 8'h10, 32'h0);
      rd(8'h10, 32'h1, 1'b0);
      xfer(1'b1, 8'h08, 32'hb);
      rd(8'h08, 32'ha, 1'b0);
      xfer(1'b1, 8'h08, 32'h1);
      rd(8'h08, 32'h1, 1'b0);
      $display("test regs done");
      // switched off: slips are ignored
      meas <= {16'd100, 16'd0, {3{16'd100}}};
      rev(3'b011, 1'b0);
      chk(32'({slip, start, trip, cur_ok}), 32'h0);
      $display("test off done");
      // one flag starts only; the second trips for the set width; trip irq only
      xfer(1'b1, 8'h00, 32'h1);
      xfer(1'b1, 8'h10, 32'h3);
      xfer(1'b1, 8'h1c, 32'h2);
      rev(3'b001, 1'b0);
      chk(32'({slip, start, trip, irq}), 32'b001100);
      trip_cyc = 0;
      rev(3'b010, 1'b0);
      repeat (30) @(posedge clk);
      chk(32'(trip_cyc >= 9 && trip_cyc <= 12), 32'h1);
      chk(32'({slip, start, irq}), 32'b01111);
      // status word: currents ok, two flags, two loops counting, pulse over, start held
      rd(8'h14, 32'h76d, 1'b0);
      rd(8'h18, 32'h3, 1'b0);
      xfer(1'b1, 8'h18, 32'h3);
      rd(8'h18, 32'h0, 1'b0);
      chk(32'(irq), 32'h0);
      $display("test vote done");
      // no re-entry: the dead timer clears the loops
      repeat (4100) @(posedge clk);
      chk(32'({slip, start}), 32'h0);
      $display("test dead done");
      // block holds start and trip low even with every flag set
      blk <= 1'b1;
      rev(3'b111, 1'b0);
      chk(32'({slip, start, trip}), 32'b11100);
      blk <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'({start, trip}), 32'b11);
      $display("test block done");
      // two revolutions per flag; a same-side exit drops the count
      xfer(1'b1, 8'h08, 32'h2);
      rev(3'b111, 1'b1);
      chk(32'(slip), 32'h0);
      rev(3'b001, 1'b0);
      chk(32'(slip), 32'h0);
      rev(3'b001, 1'b0);
      chk(32'(slip), 32'h1);
      $display("test count done");
      // threshold below range is clamped, then random currents near it
      xfer(1'b1, 8'h04, 32'h5);
      rd(8'h04, 32'h0a, 1'b0);
      repeat (24) begin
         thr = $urandom_range(10, 30);
         xfer(1'b1, 8'h04, 32'(thr));
         meas <= {16'(thr - 2 + $urandom_range(0, 4)), 16'($urandom_range(0, thr / 6 + 1)),
            16'(thr - 1 + $urandom_range(0, 2)), 16'(thr - 1 + $urandom_range(0, 2)),
            16'(thr - 1 + $urandom_range(0, 2))};
         repeat (3) @(posedge clk);
         chk(32'(cur_ok), 32'(exp_cur(thr, meas)));
      end
      $display("test current done");
      // switching off clears the loops at once
      xfer(1'b1, 8'h00, 32'h0);
      repeat (2) @(posedge clk);
      chk(32'({slip, start, trip, cur_ok}), 32'h0);
      $display("test reoff done");
      wrap_up();
   end
endmodule // pss_trip_tb
